/* verilog/odc_regs.sv */
// Purpose: Four-register output driver control bank with decoded controls
// Assumes: Serial control bus decoder presents address, write and read strobes
// Notes:   Reserved bits are read-only zero; reads answer the next cycle
//
// Contract
// - Bit 7 powers up left DAC
// - Bit 6 powers up right DAC
// - Two-bit left common output role select
// - Three-bit right common output role select
// - Bit 2 enables short-circuit protection
// - Protection with bit 1 clear limits current
// - Protection with bit 1 set powers down
// - Reserved register reads zero, never written
// - Two-bit common-mode level select
// - Left bypass off or positive pin
// - Right bypass off or positive pin
// - Soft-step rate: one, two fs, off

`default_nettype none

module odc_regs
(
	input  wire logic            i_clk,
	input  wire logic            i_rstn,
	input  wire logic [7:0]      i_addr,
	input  wire logic            i_wr,
	input  wire logic [7:0]      i_wdata,
	input  wire logic            i_rd,
	output logic      [7:0]      o_rdata,
	output logic                 o_rvalid,
	output odc_pkg::odc_ctrl_s   o_ctrl
);
	import odc_pkg::*;

	logic [7:0] dac_pwr_q;
	logic [7:0] hp_drv_q;
	logic [7:0] out_stg_q;
	odc_ctrl_s  ctrl_d;

	// Masked write: only documented R/W bits ever store a one
	function automatic logic [7:0] wr_val(input logic [7:0] d, input logic [7:0] m);
		wr_val = d & m;
	endfunction : wr_val

	// ****************************************************************
	// Register storage
	// ****************************************************************

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dac_pwr_q <= ODC_RST_VAL;
		end else if (i_wr && i_addr == ODC_OFS_DAC_PWR) begin
			dac_pwr_q <= wr_val(i_wdata, ODC_MASK_DAC_PWR);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hp_drv_q <= ODC_RST_VAL;
		end else if (i_wr && i_addr == ODC_OFS_HP_DRV) begin
			hp_drv_q <= wr_val(i_wdata, ODC_MASK_HP_DRV);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			out_stg_q <= ODC_RST_VAL;
		end else if (i_wr && i_addr == ODC_OFS_OUT_STG) begin
			out_stg_q <= wr_val(i_wdata, ODC_MASK_OUT_STG);
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************

	// reserved reads zero; unmapped addresses read zero too
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata  <= ODC_RST_VAL;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			if (i_rd) begin
				case (i_addr)
					ODC_OFS_DAC_PWR: o_rdata <= dac_pwr_q;
					ODC_OFS_HP_DRV:  o_rdata <= hp_drv_q;
					ODC_OFS_OUT_STG: o_rdata <= out_stg_q;
					default:         o_rdata <= ODC_RST_VAL;
				endcase
			end
		end
	end

	// ****************************************************************
	// Control decode
	// ****************************************************************

	// Field decode, shared by the live path and the reset image of the controls
	function automatic odc_ctrl_s decode_ctrl(input logic [7:0] dac, input logic [7:0] hp,
		input logic [7:0] stg);
		odc_ctrl_s c;
		c = '0;
		c.left_dac_pwr          = dac[7];
		c.right_dac_pwr         = dac[6];
		c.left_common_out_cfg   = dac[5:4];
		c.right_common_out_cfg  = hp[5:3];
		c.short_prot_en         = hp[2];
		c.short_limit_current   = hp[2] & ~hp[1];
		c.short_auto_pwr_down   = hp[2] & hp[1];
		c.common_mode_level_sel = stg[7:6];
		c.left_second_line_in_pos_bypass  = (stg[5:4] == ODC_BYP_ON);
		c.right_second_line_in_pos_bypass = (stg[3:2] == ODC_BYP_ON);
		c.vol_step_every_fs     = (stg[1:0] == ODC_SOFT_1FS);
		c.vol_step_every_2fs    = (stg[1:0] == ODC_SOFT_2FS);
		c.vol_step_immediate    = (stg[1:0] == ODC_SOFT_OFF);
		return c;
	endfunction : decode_ctrl

	// Reset image decodes the zeroed registers, so the stepping mode is valid in reset
	localparam odc_ctrl_s ODC_CTRL_RST = decode_ctrl(ODC_RST_VAL, ODC_RST_VAL, ODC_RST_VAL);

	// Reserved codes pass through undecoded; software must not use them
	always_comb begin
		ctrl_d = decode_ctrl(dac_pwr_q, hp_drv_q, out_stg_q);
	end

	// Registered so the analog controls never glitch
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ctrl <= ODC_CTRL_RST; // Same as the decode of all-zero registers
		end else begin
			o_ctrl <= ctrl_d;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	property p_left_pwr;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_addr == ODC_OFS_DAC_PWR) |-> ##2 o_ctrl.left_dac_pwr == $past(i_wdata[7], 2);
	endproperty
	a_left_pwr: assert property (p_left_pwr) else $error("left dac power wrong");

	property p_right_pwr;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_addr == ODC_OFS_DAC_PWR) |-> ##2 o_ctrl.right_dac_pwr == $past(i_wdata[6], 2);
	endproperty
	a_right_pwr: assert property (p_right_pwr) else $error("right dac power wrong");

	property p_lcom;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_addr == ODC_OFS_DAC_PWR) |-> ##2 o_ctrl.left_common_out_cfg == $past(i_wdata[5:4], 2);
	endproperty
	a_lcom: assert property (p_lcom) else $error("left common config wrong");

	property p_rcom;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_addr == ODC_OFS_HP_DRV) |-> ##2 o_ctrl.right_common_out_cfg == $past(i_wdata[5:3], 2);
	endproperty
	a_rcom: assert property (p_rcom) else $error("right common config wrong");

	property p_prot;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_addr == ODC_OFS_HP_DRV) |-> ##2 o_ctrl.short_prot_en == $past(i_wdata[2], 2);
	endproperty
	a_prot: assert property (p_prot) else $error("protection enable wrong");

	property p_limit;
		@(posedge i_clk) disable iff (!i_rstn)
		o_ctrl.short_limit_current |-> o_ctrl.short_prot_en && !o_ctrl.short_auto_pwr_down;
	endproperty
	a_limit: assert property (p_limit) else $error("limit mode inconsistent");

	property p_pdown;
		@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_ctrl.short_auto_pwr_down) |-> $past(hp_drv_q[1]) && $past(hp_drv_q[2]);
	endproperty
	a_pdown: assert property (p_pdown) else $error("power-down mode wrong");

	property p_rsvd_read;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_rd && i_addr == ODC_OFS_RSVD) |=> o_rvalid && o_rdata == ODC_RST_VAL;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved register nonzero");

	property p_vcm;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && i_addr == ODC_OFS_OUT_STG) |-> ##2 o_ctrl.common_mode_level_sel == $past(i_wdata[7:6], 2);
	endproperty
	a_vcm: assert property (p_vcm) else $error("common-mode select wrong");

	property p_lbyp;
		@(posedge i_clk) disable iff (!i_rstn)
		o_ctrl.left_second_line_in_pos_bypass |-> $past(out_stg_q[5:4]) == ODC_BYP_ON;
	endproperty
	a_lbyp: assert property (p_lbyp) else $error("left bypass wrong");

	property p_rbyp;
		@(posedge i_clk) disable iff (!i_rstn)
		o_ctrl.right_second_line_in_pos_bypass |-> $past(out_stg_q[3:2]) == ODC_BYP_ON;
	endproperty
	a_rbyp: assert property (p_rbyp) else $error("right bypass wrong");

	property p_soft;
		@(posedge i_clk) disable iff (!i_rstn)
		$onehot0({o_ctrl.vol_step_every_fs, o_ctrl.vol_step_every_2fs, o_ctrl.vol_step_immediate});
	endproperty
	a_soft: assert property (p_soft) else $error("soft-step decode wrong");

	property p_rsvd_bits;
		@(posedge i_clk) disable iff (!i_rstn)
		dac_pwr_q[3:0] == 4'h0 && hp_drv_q[7:6] == 2'h0 && hp_drv_q[0] == 1'b0;
	endproperty
	a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bit set");

	c_left_on:   cover property (@(posedge i_clk) disable iff (!i_rstn) o_ctrl.left_dac_pwr);
	c_pdown:     cover property (@(posedge i_clk) disable iff (!i_rstn) o_ctrl.short_auto_pwr_down);
	c_byp:       cover property (@(posedge i_clk) disable iff (!i_rstn)
		o_ctrl.left_second_line_in_pos_bypass && o_ctrl.right_second_line_in_pos_bypass);
	c_rsvd_rd:   cover property (@(posedge i_clk) disable iff (!i_rstn)
		i_rd && i_addr == ODC_OFS_RSVD);

endmodule : odc_regs

`default_nettype wire

/* verilog/odc_pkg.sv */
// Purpose: Shared constants and types for the output driver control bank
// Assumes: Registers are 8 bits, reached by an 8-bit address register port
// Notes:   Register offsets, writable masks and field codes are named here once

`default_nettype none

package odc_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ODC_OFS_DAC_PWR  = 8'h25;
	localparam logic [7:0] ODC_OFS_HP_DRV   = 8'h26;
	localparam logic [7:0] ODC_OFS_RSVD     = 8'h27;
	localparam logic [7:0] ODC_OFS_OUT_STG  = 8'h28;

	// ****************************************************************
	// Reset values and writable masks
	// ****************************************************************
	localparam logic [7:0] ODC_RST_VAL      = 8'h00;
	localparam logic [7:0] ODC_MASK_DAC_PWR = 8'hF0;
	localparam logic [7:0] ODC_MASK_HP_DRV  = 8'h3E;
	localparam logic [7:0] ODC_MASK_OUT_STG = 8'hFF;

	// ****************************************************************
	// Field codes
	// ****************************************************************
	localparam logic [1:0] ODC_LCOM_RSVD    = 2'h3;
	localparam logic [2:0] ODC_RCOM_MAX     = 3'h4;
	localparam logic [1:0] ODC_SOFT_1FS     = 2'h0;
	localparam logic [1:0] ODC_SOFT_2FS     = 2'h1;
	localparam logic [1:0] ODC_SOFT_OFF     = 2'h2;
	localparam logic [1:0] ODC_BYP_ON       = 2'h1;

	// Decoded controls driven toward the analog section
	typedef struct packed {
		logic       left_dac_pwr;
		logic       right_dac_pwr;
		logic [1:0] left_common_out_cfg;
		logic [2:0] right_common_out_cfg;
		logic       short_prot_en;
		logic       short_limit_current;
		logic       short_auto_pwr_down;
		logic [1:0] common_mode_level_sel;
		logic       left_second_line_in_pos_bypass;
		logic       right_second_line_in_pos_bypass;
		logic       vol_step_every_fs;
		logic       vol_step_every_2fs;
		logic       vol_step_immediate;
	} odc_ctrl_s;

endpackage : odc_pkg

`default_nettype wire

/* sim/output_driver_control_regs_tb_top.sv */
// Purpose: Self-checking bench for the output driver control bank
// Assumes: Strobe and address port; a read answers one cycle after its strobe
// Notes:   Reads are matched against a queue of expected values
`default_nettype none
module output_driver_control_regs_tb_top;
	import odc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic        o_rvalid;
	odc_ctrl_s   o_ctrl;
	logic [7:0]  img [4];
	logic [7:0]  expq [$];
	logic [31:0] rs = 32'hEE987B3B;
	int          bad_count = 0, tests_run = 0;
	// ************************************************************
	// Clock and device
	// ************************************************************
	always #12.5 i_clk = ~i_clk;
	odc_regs i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr(i_wr),
		.i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_ctrl(o_ctrl));
	// ************************************************************
	// Reference model and helpers
	// ************************************************************
	// Writable bits per offset; reserved and unmapped places keep nothing
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			ODC_OFS_DAC_PWR: return ODC_MASK_DAC_PWR;
			ODC_OFS_HP_DRV:  return ODC_MASK_HP_DRV;
			ODC_OFS_OUT_STG: return ODC_MASK_OUT_STG;
			default:         return 8'h00;
		endcase
	endfunction : wmask
	// Software clears reserved bits and codes
	function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d & wmask(a);
		if (a == ODC_OFS_DAC_PWR && v[5:4] == ODC_LCOM_RSVD) v[5] = 1'b0;
		if (a == ODC_OFS_HP_DRV && v[5:3] > ODC_RCOM_MAX) v[5] = 1'b0;
		if (a == ODC_OFS_OUT_STG) v = v & 8'hD7;
		if (a == ODC_OFS_OUT_STG && v[1:0] == 2'h3) v[0] = 1'b0;
		return v;
	endfunction : legal
	function automatic odc_ctrl_s exp_ctrl();
		odc_ctrl_s c;
		c.left_dac_pwr = img[0][7];
		c.right_dac_pwr = img[0][6];
		c.left_common_out_cfg = img[0][5:4];
		c.right_common_out_cfg = img[1][5:3];
		c.short_prot_en = img[1][2];
		c.short_limit_current = img[1][2] & ~img[1][1];
		c.short_auto_pwr_down = img[1][2] & img[1][1];
		c.common_mode_level_sel = img[3][7:6];
		c.left_second_line_in_pos_bypass = (img[3][5:4] == 2'h1);
		c.right_second_line_in_pos_bypass = (img[3][3:2] == 2'h1);
		c.vol_step_every_fs = (img[3][1:0] == ODC_SOFT_1FS);
		c.vol_step_every_2fs = (img[3][1:0] == ODC_SOFT_2FS);
		c.vol_step_immediate = (img[3][1:0] == ODC_SOFT_OFF);
		return c;
	endfunction : exp_ctrl
	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction : rnd
	task automatic fail(input string m);
		$display("Error at %0t: %s", $time, m);
		bad_count++;
	endtask : fail
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) fail("read data differs");
	endtask : chk_rd
	task automatic chk_ctrl(input odc_ctrl_s exp);
		tests_run++;
		if (o_ctrl !== exp) fail("decoded controls differ");
	endtask : chk_ctrl
	task automatic summarize();
		$display("Counts: %0d compared, %0d bad", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	// ************************************************************
	// Bus tasks
	// ************************************************************
	// Controls follow a write one edge after it is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		if (wmask(a) != 8'h00) img[a - ODC_OFS_DAC_PWR] = d & wmask(a);
		@(posedge i_clk);
		#1 chk_ctrl(exp_ctrl());
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		expq.push_back(wmask(a) == 8'h00 ? 8'h00 : img[a - ODC_OFS_DAC_PWR]);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask : rd
	task automatic rd_all();
		for (int a = 8'h24; a <= 8'h29; a++) rd(8'(a));
		for (int n = 0; n < 10 && expq.size() != 0; n++) @(posedge i_clk);
		if (expq.size() != 0) begin
			fail("read answer missing");
			summarize();
		end
	endtask : rd_all
	task automatic do_reset();
		i_rstn <= 1'b0;
		img = '{default: 8'h00};
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1 chk_ctrl(exp_ctrl());
	endtask : do_reset
	// Read answers are matched in order of issue
	always @(posedge i_clk) begin
		if (o_rvalid === 1'b1) begin
			if (expq.size() == 0) fail("unexpected read answer");
			else chk_rd(o_rdata, expq.pop_front());
		end
	end
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		logic [7:0] a;
		do_reset();
		rd_all();
		$display("Test reset_values done");
		// Deliberate misuse: reserved places must refuse the ones
		for (int k = 0; k < 4; k++) wr(8'(ODC_OFS_DAC_PWR + k), 8'hFF);
		rd_all();
		$display("Test reserved_bits done");
		// Every protection mode and every code of the stage fields
		for (int k = 0; k < 4; k++) begin
			wr(ODC_OFS_HP_DRV, 8'(k << 1));
			wr(ODC_OFS_OUT_STG, legal(ODC_OFS_OUT_STG, 8'(k * 8'h55)));
		end
		$display("Test field_codes done");
		repeat (60) begin
			a = 8'h24 + (rnd() % 8'h05);
			if (rnd() > 8'h60 && wmask(a) != 8'h00) begin
				wr(a, legal(a, rnd()));
			end else begin
				rd(a);
			end
		end
		rd_all();
		$display("Test random_traffic done");
		wr(ODC_OFS_DAC_PWR, 8'hC0);
		do_reset();
		rd_all();
		$display("Test mid_reset done");
		summarize();
	end
endmodule : output_driver_control_regs_tb_top
`default_nettype wire
